// [src/adcp_defines.vh]
/*
  Constants for the ADC post-processing path: sample width, clamp codes,
  filter shift, serial output framing and the control-port address, bits and reset value.
  Assumes it is included by the design file and by the bench.
*/
// Functional notes
// - Samples are 24-bit two's complement values.
// - Out-of-range inputs clamp to fixed limit codes.
// - High-pass stage removes DC by default.
// - Corner tracks sample rate; filter runs per sample.
// - Bypass bit skips the high-pass stage.
// - Hold bit freezes and keeps subtracting offset.
// - Mute bit zeroes the stereo output.
// - Configuration arrives over SPI or I2C port.
// - Serial output shifts MSB first, two's complement.
`ifndef ADCP_DEFINES_VH
`define ADCP_DEFINES_VH
`define ADCP_SMP_W        24
`define ADCP_POS_LIMIT    24'h7FFFFF
`define ADCP_NEG_LIMIT    24'h800000
`define ADCP_ACC_W        40
`define ADCP_DC_SHIFT     12
`define ADCP_CTL_W        8
`define ADCP_BIT_BYPASS   0
`define ADCP_BIT_HOLD     1
`define ADCP_BIT_MUTE     2
`define ADCP_I2C_ADDR     7'h48
`define ADCP_CTL_RESET    8'h00
`define ADCP_FRAME_BITS   6'h30
`define ADCP_HALF_BITS    6'h18
`define ADCP_SCLK_DIV     4'h2
`endif

// [src/adcp_fifo.v]
/*
  Holds no logic: the small valid/ready FIFO sits beside the path logic
  in adcp_path.v, so that one design file carries the whole block.
  Assumes the build reads adcp_path.v as well.
*/

// [src/adcp_path.v]
/*
  ADC post-processing path: clamp, DC-removing high-pass filter with
  bypass and hold, mute, a 4-word FIFO and an MSB-first serial output.
  Control bits arrive over an SPI or I2C slave port on sampled pins.
  Assumes converter samples arrive as a valid pulse in the clock domain,
  wider than 24 bits so that overrange can be seen, and that control
  pins are asynchronous.
*/
`timescale 1ns/10ps
`default_nettype none
`include "adcp_defines.vh"
module adcp_path #(
  parameter RAW_W = 26,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  // Clock and reset.
  input  wire             sys_clk_in,
  input  wire             rst_b_in,
  // Converter samples.
  input  wire [RAW_W-1:0] raw_left_in,
  input  wire [RAW_W-1:0] raw_right_in,
  input  wire             raw_valid_in,
  output reg              raw_ready_out,
  // Control port pins.
  input  wire             ctl_i2c_mode_in,
  input  wire             ctl_cs_b_in,
  input  wire             ctl_clk_in,
  input  wire             ctl_data_in,
  output reg              ctl_data_out,
  output reg              ctl_data_oe_b_out,
  // Serial audio output.
  output reg              aud_sclk_out,
  output reg              aud_lrck_out,
  output reg              aud_sdout_out
);
  localparam SW = `ADCP_SMP_W;
  localparam ACW = `ADCP_ACC_W;

  function [SW-1:0] sat24;
    input [RAW_W-1:0] v;
    begin
      if (!v[RAW_W-1] && (v[RAW_W-2:SW-1] != {(RAW_W-SW){1'b0}}))
        sat24 = `ADCP_POS_LIMIT;
      else if (v[RAW_W-1] && (v[RAW_W-2:SW-1] != {(RAW_W-SW){1'b1}}))
        sat24 = `ADCP_NEG_LIMIT;
      else
        sat24 = v[SW-1:0];
    end
  endfunction

  function [SW-1:0] sat_diff;
    input [SW:0] d;
    begin
      if (d[SW] != d[SW-1])
        sat_diff = d[SW] ? `ADCP_NEG_LIMIT : `ADCP_POS_LIMIT;
      else
        sat_diff = d[SW-1:0];
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers.
  // ----------------------------------------------------------------
  reg [3:0] s1_r;
  reg [3:0] s2_r;
  reg       clk_d_r;
  reg       dat_d_r;
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s1_r    <= 4'hF;
      s2_r    <= 4'hF;
      clk_d_r <= 1'b1;
      dat_d_r <= 1'b1;
    end else begin
      s1_r    <= {ctl_i2c_mode_in, ctl_cs_b_in, ctl_clk_in, ctl_data_in};
      s2_r    <= s1_r;
      clk_d_r <= s2_r[1];
      dat_d_r <= s2_r[0];
    end
  end
  wire i2c_mode = s2_r[3];
  wire cs_b     = s2_r[2];
  wire c_rise   = s2_r[1] & ~clk_d_r;
  wire c_fall   = ~s2_r[1] & clk_d_r;
  wire i2c_sta  = s2_r[1] & clk_d_r & dat_d_r & ~s2_r[0];
  wire i2c_sto  = s2_r[1] & clk_d_r & ~dat_d_r & s2_r[0];

  // ----------------------------------------------------------------
  // Control port: one byte written sets the control bits.
  // ----------------------------------------------------------------
  // A transfer is address byte then control byte; the address is
  // checked only in I2C mode, SPI relies on the chip select.
  localparam CP_IDLE = 2'h0;
  localparam CP_ADDR = 2'h1;
  localparam CP_DATA = 2'h2;
  localparam CP_ACK  = 2'h3;
  reg [1:0]            cp_st_r;
  reg [3:0]            cp_bits_r;
  reg [7:0]            cp_sh_r;
  reg [`ADCP_CTL_W-1:0] ctl_r;
  wire [7:0]           cp_byte = {cp_sh_r[6:0], dat_d_r};
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cp_st_r           <= CP_IDLE;
      cp_bits_r         <= 4'h0;
      cp_sh_r           <= 8'h00;
      ctl_r             <= `ADCP_CTL_RESET;
      ctl_data_out      <= 1'b0;
      ctl_data_oe_b_out <= 1'b1;
    end else if ((i2c_mode & i2c_sta) | (~i2c_mode & cs_b)) begin
      cp_st_r           <= (i2c_mode | ~cs_b) ? CP_ADDR : CP_IDLE;
      cp_bits_r         <= 4'h0;
      ctl_data_oe_b_out <= 1'b1;
      if (~i2c_mode & cs_b) cp_st_r <= CP_IDLE;
    end else if (i2c_mode & i2c_sto) begin
      cp_st_r           <= CP_IDLE;
      ctl_data_oe_b_out <= 1'b1;
    end else begin
      case (cp_st_r)
        CP_IDLE: begin
          if (~i2c_mode & ~cs_b) cp_st_r <= CP_ADDR;
        end
        CP_ADDR, CP_DATA: begin
          if (c_rise) begin
            cp_sh_r   <= cp_byte;
            cp_bits_r <= cp_bits_r + 4'h1;
            if (cp_bits_r == 4'h7) begin
              cp_bits_r   <= 4'h0;
              if (cp_st_r == CP_DATA) ctl_r <= cp_byte;
              if (!i2c_mode) begin
                cp_st_r <= CP_DATA;
              end else if (cp_st_r == CP_DATA || cp_byte[7:1] == `ADCP_I2C_ADDR) begin
                cp_st_r <= CP_ACK;
              end else begin
                cp_st_r <= CP_IDLE;
              end
            end
          end
        end
        CP_ACK: begin
          if (c_fall & ctl_data_oe_b_out) begin
            ctl_data_out      <= 1'b0;
            ctl_data_oe_b_out <= 1'b0;
          end else if (c_fall) begin
            ctl_data_oe_b_out <= 1'b1;
            cp_st_r           <= CP_DATA;
          end
        end
        default: cp_st_r <= CP_IDLE;
      endcase
    end
  end
  wire bypass = ctl_r[`ADCP_BIT_BYPASS];
  wire hold   = ctl_r[`ADCP_BIT_HOLD];
  wire mute   = ctl_r[`ADCP_BIT_MUTE];

  // ----------------------------------------------------------------
  // Clamp, high-pass filter and mute.
  // ----------------------------------------------------------------
  // The offset estimate is a leaky integrator updated once per sample,
  // so its corner is a fixed fraction of the sample rate.
  reg  [ACW-1:0] dc_l_r;
  reg  [ACW-1:0] dc_r_r;
  reg  [2*SW-1:0] out_r;
  reg             out_vld_r;
  wire            f_ready;
  wire [SW-1:0]   cl = sat24(raw_left_in);
  wire [SW-1:0]   cr = sat24(raw_right_in);
  wire [SW-1:0]   el = dc_l_r[ACW-1 -: SW];
  wire [SW-1:0]   er = dc_r_r[ACW-1 -: SW];
  wire [SW:0]     dl = {cl[SW-1], cl} - {el[SW-1], el};
  wire [SW:0]     dr = {cr[SW-1], cr} - {er[SW-1], er};
  wire [SW-1:0]   hl = sat_diff(dl);
  wire [SW-1:0]   hr = sat_diff(dr);
  wire [ACW-1:0]  stl = {{(ACW-SW-1){dl[SW]}}, dl} <<< (ACW-SW-`ADCP_DC_SHIFT);
  wire [ACW-1:0]  str = {{(ACW-SW-1){dr[SW]}}, dr} <<< (ACW-SW-`ADCP_DC_SHIFT);
  wire            take = raw_valid_in & raw_ready_out;
  // Ready looks one word ahead, so a loaded output register is never overwritten.
  wire            out_vld_nxt = take | (out_vld_r & ~f_ready);
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dc_l_r        <= {ACW{1'b0}};
      dc_r_r        <= {ACW{1'b0}};
      out_r         <= {(2*SW){1'b0}};
      out_vld_r     <= 1'b0;
      raw_ready_out <= 1'b0;
    end else begin
      raw_ready_out <= ~out_vld_nxt;
      if (out_vld_r & f_ready) out_vld_r <= 1'b0;
      if (take) begin
        if (!hold) begin
          dc_l_r <= dc_l_r + stl;
          dc_r_r <= dc_r_r + str;
        end
        out_vld_r <= 1'b1;
        if (mute)
          out_r <= {(2*SW){1'b0}};
        else if (bypass)
          out_r <= {cl, cr};
        else
          out_r <= {hl, hr};
      end
    end
  end

  // ----------------------------------------------------------------
  // FIFO and serial output.
  // ----------------------------------------------------------------
  wire [2*SW-1:0] f_data;
  wire            f_valid;
  reg             f_pop_r;
  adcp_fifo #(.WIDTH(2*SW), .DEPTH(DEPTH), .AW(AW)) u_fifo (
    .clk_in       (sys_clk_in),
    .rst_b_in     (rst_b_in),
    .wr_data_in   (out_r),
    .wr_valid_in  (out_vld_r),
    .wr_ready_out (f_ready),
    .rd_data_out  (f_data),
    .rd_valid_out (f_valid),
    .rd_ready_in  (f_pop_r)
  );

  // Frames are only sent when a sample is waiting; the link idles
  // rather than repeating stale data.
  reg [3:0]      div_r;
  reg [5:0]      bit_r;
  reg [2*SW-1:0] sh_r;
  reg            busy_r;
  wire           tick = (div_r == `ADCP_SCLK_DIV - 4'h1);
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div_r         <= 4'h0;
      bit_r         <= 6'h00;
      sh_r          <= {(2*SW){1'b0}};
      busy_r        <= 1'b0;
      f_pop_r       <= 1'b0;
      aud_sclk_out  <= 1'b0;
      aud_lrck_out  <= 1'b0;
      aud_sdout_out <= 1'b0;
    end else begin
      f_pop_r <= 1'b0;
      div_r   <= tick ? 4'h0 : div_r + 4'h1;
      if (!busy_r) begin
        aud_sclk_out <= 1'b0;
        if (f_valid & ~f_pop_r & tick) begin
          sh_r    <= f_data;
          f_pop_r <= 1'b1;
          busy_r  <= 1'b1;
          bit_r   <= 6'h00;
        end
      end else if (tick) begin
        aud_sclk_out <= ~aud_sclk_out;
        if (!aud_sclk_out) begin
          aud_sdout_out <= sh_r[2*SW-1];
          aud_lrck_out  <= (bit_r >= `ADCP_HALF_BITS);
          sh_r          <= {sh_r[2*SW-2:0], 1'b0};
        end else begin
          bit_r <= bit_r + 6'h01;
          if (bit_r == `ADCP_FRAME_BITS - 6'h01) busy_r <= 1'b0;
        end
      end
    end
  end
endmodule // adcp_path

// ----------------------------------------------------------------
// Small FIFO with valid/ready on both sides.
// ----------------------------------------------------------------
module adcp_fifo #(
  parameter WIDTH = 48,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  // Clock and reset.
  input  wire             clk_in,
  input  wire             rst_b_in,
  // Fill side.
  input  wire [WIDTH-1:0] wr_data_in,
  input  wire             wr_valid_in,
  output wire             wr_ready_out,
  // Drain side.
  output wire [WIDTH-1:0] rd_data_out,
  output wire             rd_valid_out,
  input  wire             rd_ready_in
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0]    wp_r;
  reg [AW-1:0]    rp_r;
  reg [AW:0]      cnt_r;
  wire            do_wr;
  wire            do_rd;
  assign wr_ready_out = (cnt_r != DEPTH[AW:0]);
  assign rd_valid_out = (cnt_r != {(AW+1){1'b0}});
  assign rd_data_out  = mem_r[rp_r];
  assign do_wr        = wr_valid_in & wr_ready_out;
  assign do_rd        = rd_valid_out & rd_ready_in;
  always @(posedge clk_in) begin
    if (do_wr) begin
      mem_r[wp_r] <= wr_data_in;
    end
  end
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wp_r <= wp_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_rd) begin
        rp_r <= rp_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_wr & ~do_rd) begin
        cnt_r <= cnt_r + {{AW{1'b0}}, 1'b1};
      end else if (do_rd & ~do_wr) begin
        cnt_r <= cnt_r - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // adcp_fifo
`default_nettype wire

// [tb/adcp_path_chk.sv]
/* Checker for adcp_path ports: bit clock shape, channel order and acks.
   Assumes one clock domain and a bind to every adcp_path. */
`timescale 1ns/10ps
`default_nettype none
module adcp_path_chk #(
  parameter RAW_W = 26
) (
  // Watched ports.
  input wire logic             sys_clk_in,
  input wire logic             rst_b_in,
  input wire logic [RAW_W-1:0] raw_left_in,
  input wire logic [RAW_W-1:0] raw_right_in,
  input wire logic             raw_valid_in,
  input wire logic             raw_ready_out,
  input wire logic             ctl_i2c_mode_in,
  input wire logic             ctl_cs_b_in,
  input wire logic             ctl_clk_in,
  input wire logic             ctl_data_in,
  input wire logic             ctl_data_out,
  input wire logic             ctl_data_oe_b_out,
  input wire logic             aud_sclk_out,
  input wire logic             aud_lrck_out,
  input wire logic             aud_sdout_out
);
  logic       sclk_d_r;
  logic [5:0] bit_n_r;
  // Counts bit clock rises so that the channel select can be tied to the bit position.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sclk_d_r <= 1'b0;
      bit_n_r  <= 6'h00;
    end else begin
      sclk_d_r <= aud_sclk_out;
      if (aud_sclk_out && !sclk_d_r) begin
        bit_n_r <= (bit_n_r == 6'h2F) ? 6'h00 : bit_n_r + 6'h01;
      end
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  a_sclk_high: assert property ($rose(aud_sclk_out) |-> aud_sclk_out[*2] ##1 !aud_sclk_out)
    else $error("bit clock high phase wrong");
  a_sclk_low: assert property ($fell(aud_sclk_out) |-> !aud_sclk_out[*2])
    else $error("bit clock low phase short");
  a_data_hold: assert property (sclk_d_r |-> $stable(aud_sdout_out))
    else $error("serial data moved away from a rise");
  a_lrck_hold: assert property (sclk_d_r |-> $stable(aud_lrck_out))
    else $error("channel select moved away from a rise");
  a_lrck_half: assert property (aud_sclk_out && !sclk_d_r |-> aud_lrck_out == (bit_n_r >= 6'h18))
    else $error("channel select out of step");
  a_ack_i2c: assert property (!ctl_data_oe_b_out |-> ctl_i2c_mode_in && !ctl_data_out)
    else $error("data line pulled outside two-wire mode");
  a_ack_scl_low: assert property ($fell(ctl_data_oe_b_out) |-> !ctl_clk_in)
    else $error("ack began with control clock high");
  a_ack_len: assert property ($fell(ctl_data_oe_b_out) |-> !ctl_data_oe_b_out[*4] ##[1:12] ctl_data_oe_b_out)
    else $error("ack length wrong");
endmodule // adcp_path_chk
bind adcp_path adcp_path_chk #(.RAW_W(RAW_W)) u_chk (
  .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .raw_left_in(raw_left_in), .raw_right_in(raw_right_in),
  .raw_valid_in(raw_valid_in), .raw_ready_out(raw_ready_out), .ctl_i2c_mode_in(ctl_i2c_mode_in),
  .ctl_cs_b_in(ctl_cs_b_in), .ctl_clk_in(ctl_clk_in), .ctl_data_in(ctl_data_in), .ctl_data_out(ctl_data_out),
  .ctl_data_oe_b_out(ctl_data_oe_b_out), .aud_sclk_out(aud_sclk_out), .aud_lrck_out(aud_lrck_out),
  .aud_sdout_out(aud_sdout_out)
);
`default_nettype wire

// [tb/adcp_aud_rx.sv]
/* Listener on the serial audio output; collects 48-bit stereo frames.
   Assumes the bit clock stands low between frames. */
`timescale 1ns/10ps
`default_nettype none
module adcp_aud_rx (
  // Serial audio pins.
  input wire logic rst_b_in,
  input wire logic aud_sclk_in,
  input wire logic aud_lrck_in,
  input wire logic aud_sdout_in
);
  logic [47:0] sh_r;
  int          n_r;
  logic        side_err_r = 1'b0;
  logic [47:0] q [$];
  // Sampling on the falling edge gives the sender a full half bit of settling.
  always @(negedge aud_sclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      n_r = 0;
    end else begin
      if (aud_lrck_in !== (n_r >= 24)) side_err_r = 1'b1;
      sh_r = {sh_r[46:0], aud_sdout_in};
      n_r++;
      if (n_r == 48) begin
        q.push_back(sh_r);
        n_r = 0;
      end
    end
  end
endmodule // adcp_aud_rx
`default_nettype wire

// [tb/adcp_path_tb.sv]
/* Self-checking bench for adcp_path: sample rows, reset, filter, hold, stall.
   Assumes adcp_aud_rx on the serial output and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
`include "adcp_defines.vh"
module adcp_path_tb;
  typedef struct packed {
    logic        m;
    logic [7:0]  c;
    logic [25:0] l;
    logic [25:0] r;
    logic [23:0] el;
    logic [23:0] er;
  } adcp_row_t;
  logic        sys_clk = 1'b0;
  logic        rst_b, raw_v, mode, cs_b, cclk, sda_r, stalled;
  logic [25:0] raw_l, raw_r;
  logic [23:0] gl, gr, pv;
  wire         raw_rdy, oe_b, sclk, lrck, sdo, cdo;
  wire         cdi = sda_r & (oe_b | cdo);
  int          failures = 0;
  int          n_tests = 0;
  adcp_row_t   rows [6];
  adcp_path dut (
    .sys_clk_in(sys_clk), .rst_b_in(rst_b), .raw_left_in(raw_l), .raw_right_in(raw_r), .raw_valid_in(raw_v),
    .raw_ready_out(raw_rdy), .ctl_i2c_mode_in(mode), .ctl_cs_b_in(cs_b), .ctl_clk_in(cclk), .ctl_data_in(cdi),
    .ctl_data_out(cdo), .ctl_data_oe_b_out(oe_b), .aud_sclk_out(sclk), .aud_lrck_out(lrck), .aud_sdout_out(sdo)
  );
  adcp_aud_rx rx (.rst_b_in(rst_b), .aud_sclk_in(sclk), .aud_lrck_in(lrck), .aud_sdout_in(sdo));
  always #50 sys_clk = ~sys_clk;
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d, failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic bail;
    failures++;
    $display("unexpected at %0t: wait ran out", $time);
    summarize();
  endtask
  // Control phases of six and four clocks leave room for the two-stage synchroniser.
  task automatic cbit(input logic b, input logic chk);
    sda_r <= b;
    tick(4);
    cclk <= 1'b1;
    tick(2);
    if (chk) check({23'h0, cdi}, 24'h0);
    tick(2);
    cclk <= 1'b0;
    tick(2);
  endtask
  task automatic cbyte(input logic [7:0] v, input logic ack);
    for (int i = 7; i >= 0; i--) cbit(v[i], 1'b0);
    if (ack) cbit(1'b1, 1'b1);
  endtask
  task automatic cfg(input logic m, input logic [7:0] c);
    mode <= m;
    cclk <= m;
    sda_r <= 1'b1;
    tick(8);
    if (m) begin
      sda_r <= 1'b0;
      tick(4);
      cclk <= 1'b0;
      tick(2);
      cbyte({`ADCP_I2C_ADDR, 1'b0}, 1'b1);
      cbyte(c, 1'b1);
      sda_r <= 1'b0;
      tick(4);
      cclk <= 1'b1;
      tick(4);
      sda_r <= 1'b1;
    end else begin
      cs_b <= 1'b0;
      tick(4);
      cbyte(8'h00, 1'b0);
      cbyte(c, 1'b0);
      cs_b <= 1'b1;
    end
    tick(8);
  endtask
  task automatic send(input logic [25:0] l, input logic [25:0] r);
    int i;
    raw_l <= l;
    raw_r <= r;
    raw_v <= 1'b1;
    i = 0;
    tick(1);
    while (raw_rdy !== 1'b1) begin
      if (i > 8) stalled = 1'b1;
      i++;
      if (i > 3000) bail();
      tick(1);
    end
  endtask
  task automatic getf(output logic [23:0] l, output logic [23:0] r);
    int i;
    i = 0;
    while (rx.q.size() == 0) begin
      i++;
      if (i > 3000) bail();
      tick(1);
    end
    {l, r} = rx.q.pop_front();
  endtask
  initial begin
    {rst_b, raw_v, mode, cs_b, cclk, sda_r, stalled, raw_l, raw_r} = {6'h0F, 1'b0, 52'h0};
    rows[0] = '{1'b0, 8'h01, 26'h0123456, 26'h3FEDCBA, 24'h123456, 24'hFEDCBA};
    rows[1] = '{1'b1, 8'h01, 26'h0800000, 26'h37FFFFF, 24'h7FFFFF, 24'h800000};
    rows[2] = '{1'b0, 8'h01, 26'h1FFFFFF, 26'h2000000, 24'h7FFFFF, 24'h800000};
    rows[3] = '{1'b1, 8'h01, 26'h07FFFFF, 26'h3800000, 24'h7FFFFF, 24'h800000};
    rows[4] = '{1'b0, 8'h05, 26'h0123456, 26'h3800000, 24'h000000, 24'h000000};
    rows[5] = '{1'b1, 8'h04, 26'h1FFFFFF, 26'h0123456, 24'h000000, 24'h000000};
    tick(3);
    rst_b <= 1'b1;
    tick(2);
    foreach (rows[k]) begin
      cfg(rows[k].m, rows[k].c);
      send(rows[k].l, rows[k].r);
      raw_v <= 1'b0;
      getf(gl, gr);
      check(gl, rows[k].el);
      check(gr, rows[k].er);
      $display("row %0d done", k);
    end
    rst_b <= 1'b0;
    tick(2);
    check({19'h0, raw_rdy, sclk, lrck, sdo, oe_b}, 24'h000001);
    rst_b <= 1'b1;
    tick(2);
    check({23'h0, raw_rdy}, 24'h000001);
    $display("reset done");
    for (int k = 0; k < 8; k++) send(26'h0400000, 26'h0400000);
    raw_v <= 1'b0;
    check({23'h0, stalled}, 24'h000001);
    pv = 24'h400001;
    for (int k = 0; k < 8; k++) begin
      getf(gl, gr);
      check({23'h0, gl < pv && gl > 24'h3F0000}, 24'h000001);
      check(gr, gl);
      pv = gl;
    end
    $display("filter and stall done");
    cfg(1'b0, 8'h02);
    send(26'h0400000, 26'h0400000);
    send(26'h0400100, 26'h0400100);
    send(26'h0400000, 26'h0400000);
    raw_v <= 1'b0;
    getf(pv, gr);
    getf(gl, gr);
    check(gl, pv + 24'h000100);
    getf(gl, gr);
    check(gl, pv);
    cfg(1'b0, 8'h00);
    send(26'h0400000, 26'h0400000);
    send(26'h0400000, 26'h0400000);
    raw_v <= 1'b0;
    getf(gl, gr);
    getf(gl, gr);
    check({23'h0, gl < pv && gl > pv - 24'h001000}, 24'h000001);
    check({23'h0, rx.side_err_r}, 24'h000000);
    $display("hold and release done");
    summarize();
  end
endmodule // adcp_path_tb
`default_nettype wire
